// ---- rtl/bcc_pkg.sv ----
// Package for the battery coulomb counter: register map, fields and timing
package bcc_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned MEAS_PERIOD_MS = 440;
	localparam int unsigned CONV_TIME_MS   = 3500;
	localparam int unsigned SLEEP_IDLE_MS  = 2000;
	localparam int unsigned MEAS_CYC  = (CLK_HZ / 1000) * MEAS_PERIOD_MS;
	localparam int unsigned CONV_CYC  = (CLK_HZ / 1000) * CONV_TIME_MS;
	localparam int unsigned SLEEP_CYC = (CLK_HZ / 1000) * SLEEP_IDLE_MS;
	localparam int unsigned CNT_W     = 26;

	localparam logic [7:0] ADDR_CONFIG   = 8'h00;
	localparam logic [7:0] ADDR_TEMP     = 8'h04;
	localparam logic [7:0] ADDR_VOLT     = 8'h08;
	localparam logic [7:0] ADDR_CURRENT  = 8'h0c;
	localparam logic [7:0] ADDR_ACC      = 8'h10;
	localparam logic [7:0] ADDR_CUR_BIAS = 8'h14;
	localparam logic [7:0] ADDR_ACC_BIAS = 8'h18;

	localparam int unsigned CFG_SLEEP_EN_BIT = 0;
	localparam int unsigned CFG_BLANK_EN_BIT = 1;
	localparam int unsigned CFG_SLEEP_ST_BIT = 8;
	localparam logic CFG_SLEEP_EN_RST = 1'b0;
	localparam logic CFG_BLANK_EN_RST = 1'b0;
	localparam logic [7:0] BIAS_RST   = 8'h00;

	localparam int unsigned ACC_FRAC_W = 12;
	localparam int unsigned ACC_W      = 16 + ACC_FRAC_W;
	localparam int unsigned RAW_W      = 18;
	localparam int unsigned OFFSET_PERIOD = 1024;
	localparam logic [9:0] OFFSET_IDX  = 10'h3ff;
	localparam logic signed [15:0] SAT_POS = 16'sh7fff;
	localparam logic signed [15:0] SAT_NEG = 16'sh8000;
	localparam logic signed [15:0] CHG_BLANK_LSB = 16'sh0040;
	localparam logic signed [15:0] DIS_BLANK_LSB = 16'sh0010;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [RAW_W-1:0] cur_raw;
		logic [16:0]      volt_raw;
		logic [15:0]      temp_raw;
	} bcc_adc_t;

	typedef struct packed {
		logic                   sda_meta;
		logic                   sda_sync;
		logic                   scl_meta;
		logic                   scl_sync;
		logic                   sleep;
		logic [CNT_W-1:0]       idle_cnt;
		logic [CNT_W-1:0]       meas_cnt;
		logic [CNT_W-1:0]       conv_cnt;
		logic [9:0]             conv_idx;
		logic                   offset_conv;
		logic                   forced_conv;
		logic                   sleep_en;
		logic                   blank_en;
		logic [15:0]            temp;
		logic [15:0]            volt;
		logic [15:0]            cur;
		logic [ACC_W-1:0]       acc;
		logic [RAW_W-1:0]       offset_corr;
		logic [7:0]             cur_bias;
		logic [7:0]             acc_bias;
		logic                   aw_got;
		logic                   w_got;
		logic [7:0]             awaddr;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
	} bcc_state_t;
endpackage

// ---- rtl/bcc_counter.sv ----
// Measurement sequencer and coulomb-counting datapath with AXI4-Lite registers
// Function
// - Active mode acquires voltage, temperature, current and charge; all registers reachable.
// - Sleep stops all measurement; serial register access still works.
// - Either bus line high wakes the device from sleep at once.
// - Sleep entered only with sleep enable set and both lines low long enough.
// - Idle time is two seconds; clearing sleep enable blocks sleep entry.
// - Voltage result refreshed every 440 ms, two's complement, 4.88 mV step.
// - Voltage result saturates at 7fff when input exceeds the register range.
// - Temperature result refreshed every 440 ms, two's complement, 0.125 C step.
// - Signed current updated at each 3.5 s conversion end, 1.5625 uV step.
// - Charge currents beyond range report the saturated value 7fff.
// - Every 1024th conversion measures offset; correction serves the next 1023.
// - Offset conversion keeps the previous current and accumulates it instead.
// - New charge is previous charge plus current result plus accumulation bias.
// - Charge clamps at ffff upward and 0000 downward; hidden fraction kept.
// - Writing accumulated charge clears the hidden fraction bits.
// - Writing accumulated charge forces an immediate offset conversion.
// - After that write, measurement and accumulation resume with the second conversion.
// - Current bias is added to every raw conversion for display and accumulation.
// - Current bias is volatile signed 8-bit, applied to later conversions.
// - Biased charge results below 100 uV are never accumulated.
// - With blank enable set, discharge below 25 uV magnitude is not accumulated.
// - Discharge blank enable is cleared at reset.
// - Accumulation bias is added without any blanking check.
// - Accumulation bias is volatile signed 8-bit, applied to later accumulations.
// - A two-byte register is read as one unit so both halves match.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
module bcc_counter
	import bcc_pkg::*;
#(
	parameter int unsigned MEAS_CYCLES  = MEAS_CYC,
	parameter int unsigned CONV_CYCLES  = CONV_CYC,
	parameter int unsigned SLEEP_CYCLES = SLEEP_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        bus_data_in,
	input  wire logic        bus_clock_in,
	input  wire bcc_adc_t    adc,
	output logic             sleep_mode,
	output logic             offset_select
);

	if (MEAS_CYCLES < 2 || MEAS_CYCLES >= (1 << CNT_W)) begin : g_chk_meas
		$error("MEAS_CYCLES out of range");
	end
	if (CONV_CYCLES < 2 || CONV_CYCLES >= (1 << CNT_W)) begin : g_chk_conv
		$error("CONV_CYCLES out of range");
	end
	if (SLEEP_CYCLES < 2 || SLEEP_CYCLES >= (1 << CNT_W)) begin : g_chk_sleep
		$error("SLEEP_CYCLES out of range");
	end

	localparam logic [CNT_W-1:0] MEAS_LAST  = CNT_W'(MEAS_CYCLES - 1);
	localparam logic [CNT_W-1:0] CONV_LAST  = CNT_W'(CONV_CYCLES - 1);
	localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_CYCLES - 1);
	localparam logic [ACC_W+1:0] ACC_MAX    = {2'b00, {ACC_W{1'b1}}};

	bcc_state_t st_reg;
	bcc_state_t st_next;

	logic                    meas_tick;
	logic                    conv_end;
	logic                    lines_low;
	logic                    wr_fire;
	logic                    acc_write;
	logic signed [RAW_W+1:0] cur_sum;
	logic signed [15:0]      cur_new;
	logic signed [15:0]      acc_src;
	logic signed [15:0]      acc_term;
	logic signed [ACC_W+1:0] acc_sum;
	logic [31:0]             rd_word;
	logic                    rd_hit;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [RAW_W+1:0] v);
		if (v > RAW_W'(SAT_POS))
			sat16 = SAT_POS;
		else if (v < $signed({{(RAW_W-14){1'b1}}, 16'h8000}))
			sat16 = SAT_NEG;
		else
			sat16 = v[15:0];
	endfunction

	assign lines_low = !st_reg.sda_sync && !st_reg.scl_sync;
	assign meas_tick = !st_reg.sleep && (st_reg.meas_cnt == MEAS_LAST);
	assign conv_end  = !st_reg.sleep && (st_reg.conv_cnt == CONV_LAST);
	assign wr_fire   = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
	assign acc_write = wr_fire && (st_reg.awaddr == ADDR_ACC);

	always_comb begin
		// Raw minus offset plus sign-extended current bias
		cur_sum = $signed({{2{adc.cur_raw[RAW_W-1]}}, adc.cur_raw})
			- $signed({{2{st_reg.offset_corr[RAW_W-1]}}, st_reg.offset_corr})
			+ $signed({{(RAW_W-6){st_reg.cur_bias[7]}}, st_reg.cur_bias});
		cur_new = sat16(cur_sum);
		// Offset conversions reuse the value already displayed
		acc_src = st_reg.offset_conv ? $signed(st_reg.cur) : cur_new;
		if (acc_src > 16'sh0000 && acc_src < CHG_BLANK_LSB)
			acc_term = 16'sh0000;
		else if (st_reg.blank_en && acc_src < 16'sh0000 && acc_src > -DIS_BLANK_LSB)
			acc_term = 16'sh0000;
		else
			acc_term = acc_src;
		// Bias joins after blanking; current LSB equals one fraction LSB
		acc_sum = $signed({2'b00, st_reg.acc})
			+ $signed({{(ACC_W-14){acc_term[15]}}, acc_term})
			+ $signed({{(ACC_W-6){st_reg.acc_bias[7]}}, st_reg.acc_bias});
	end

	always_comb begin
		rd_hit = 1'b1;
		// Whole 16-bit value goes out in one beat, so halves cannot tear
		unique case (s_axi_araddr)
			ADDR_CONFIG: begin
				rd_word = '0;
				rd_word[CFG_SLEEP_EN_BIT] = st_reg.sleep_en;
				rd_word[CFG_BLANK_EN_BIT] = st_reg.blank_en;
				rd_word[CFG_SLEEP_ST_BIT] = st_reg.sleep;
			end
			ADDR_TEMP:     rd_word = {16'h0000, st_reg.temp};
			ADDR_VOLT:     rd_word = {16'h0000, st_reg.volt};
			ADDR_CURRENT:  rd_word = {16'h0000, st_reg.cur};
			ADDR_ACC:      rd_word = {16'h0000, st_reg.acc[ACC_W-1:ACC_FRAC_W]};
			ADDR_CUR_BIAS: rd_word = {24'h000000, st_reg.cur_bias};
			ADDR_ACC_BIAS: rd_word = {24'h000000, st_reg.acc_bias};
			default: begin
				rd_word = '0;
				rd_hit  = 1'b0;
			end
		endcase
	end

	always_comb begin
		st_next = st_reg;

		// Line synchronisers
		st_next.sda_meta = bus_data_in;
		st_next.sda_sync = st_reg.sda_meta;
		st_next.scl_meta = bus_clock_in;
		st_next.scl_sync = st_reg.scl_meta;

		// Power mode
		if (st_reg.sleep) begin
			if (!lines_low)
				st_next.sleep = 1'b0;
			st_next.idle_cnt = '0;
		end else if (st_reg.sleep_en && lines_low) begin
			if (st_reg.idle_cnt == SLEEP_LAST) begin
				st_next.sleep    = 1'b1;
				st_next.idle_cnt = '0;
			end else begin
				st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
			end
		end else begin
			st_next.idle_cnt = '0;
		end

		// Voltage and temperature, frozen in sleep
		if (!st_reg.sleep) begin
			st_next.meas_cnt = meas_tick ? '0 : st_reg.meas_cnt + 1'b1;
		end
		if (meas_tick) begin
			if ($signed(adc.volt_raw) > $signed({1'b0, SAT_POS}))
				st_next.volt = SAT_POS;
			else
				st_next.volt = adc.volt_raw[15:0];
			st_next.temp = adc.temp_raw;
		end

		// Current conversion sequence
		if (!st_reg.sleep) begin
			st_next.conv_cnt = conv_end ? '0 : st_reg.conv_cnt + 1'b1;
		end
		if (conv_end) begin
			st_next.forced_conv = 1'b0;
			if (st_reg.offset_conv) begin
				st_next.offset_corr = adc.cur_raw;
				// A forced calibration skips accumulation; next conversion is normal
				if (!st_reg.forced_conv) begin
					st_next.acc = acc_sum < 0 ? '0
						: (acc_sum > ACC_MAX ? {ACC_W{1'b1}} : acc_sum[ACC_W-1:0]);
				end
				st_next.conv_idx    = '0;
				st_next.offset_conv = 1'b0;
			end else begin
				st_next.cur = cur_new;
				st_next.acc = acc_sum < 0 ? '0
					: (acc_sum > ACC_MAX ? {ACC_W{1'b1}} : acc_sum[ACC_W-1:0]);
				st_next.conv_idx    = st_reg.conv_idx + 1'b1;
				st_next.offset_conv = (st_reg.conv_idx + 1'b1) == OFFSET_IDX;
			end
		end

		// AXI write path
		if (s_axi_awvalid && s_axi_awready) begin
			st_next.aw_got = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_next.w_got = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = RESP_OKAY;
			unique case (st_reg.awaddr)
				ADDR_CONFIG: begin
					if (st_reg.wstrb[0]) begin
						st_next.sleep_en = st_reg.wdata[CFG_SLEEP_EN_BIT];
						st_next.blank_en = st_reg.wdata[CFG_BLANK_EN_BIT];
					end
				end
				ADDR_ACC: begin
					st_next.acc = {merge16(st_reg.acc[ACC_W-1:ACC_FRAC_W], st_reg.wdata,
						st_reg.wstrb), {ACC_FRAC_W{1'b0}}};
					// Restart with a calibration conversion so the new count starts clean
					st_next.conv_cnt    = '0;
					st_next.offset_conv = 1'b1;
					st_next.forced_conv = 1'b1;
					st_next.conv_idx    = '0;
				end
				ADDR_CUR_BIAS: begin
					if (st_reg.wstrb[0])
						st_next.cur_bias = st_reg.wdata[7:0];
				end
				ADDR_ACC_BIAS: begin
					if (st_reg.wstrb[0])
						st_next.acc_bias = st_reg.wdata[7:0];
				end
				ADDR_TEMP, ADDR_VOLT, ADDR_CURRENT: st_next.bresp = RESP_OKAY;
				default: st_next.bresp = RESP_SLVERR;
			endcase
		end
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;

		// AXI read path
		if (s_axi_arvalid && s_axi_arready) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd_word;
			st_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg          <= '0;
			st_reg.sleep_en <= CFG_SLEEP_EN_RST;
			st_reg.blank_en <= CFG_BLANK_EN_RST;
			st_reg.cur_bias <= BIAS_RST;
			st_reg.acc_bias <= BIAS_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
	assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;
	assign sleep_mode    = st_reg.sleep;
	assign offset_select = st_reg.offset_conv;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_acc_write;
		acc_write;
	endsequence

	sequence s_forced_cal_done;
		conv_end && st_reg.forced_conv;
	endsequence

	chk_wake_on_line: assert property (
		st_reg.sleep && !lines_low |=> !st_reg.sleep)
		else $error("sleep held with a bus line high");

	chk_sleep_entry: assert property (
		$rose(st_reg.sleep) |-> $past(st_reg.sleep_en) && $past(st_reg.idle_cnt) == SLEEP_LAST)
		else $error("sleep entered without enable and idle time");

	chk_no_conv_asleep: assert property (
		st_reg.sleep |=> $stable(st_reg.cur) && $stable(st_reg.volt) && $stable(st_reg.temp))
		else $error("measurement changed during sleep");

	chk_volt_saturate: assert property (
		meas_tick && !wr_fire && $signed(adc.volt_raw) > $signed({1'b0, SAT_POS})
		|=> st_reg.volt == SAT_POS)
		else $error("voltage not saturated");

	chk_offset_schedule: assert property (
		conv_end && !st_reg.offset_conv && st_reg.conv_idx == OFFSET_IDX - 1'b1 && !wr_fire
		|=> st_reg.offset_conv)
		else $error("offset conversion not scheduled at 1024th");

	chk_offset_keeps_cur: assert property (
		conv_end && st_reg.offset_conv |=> $stable(st_reg.cur))
		else $error("current changed on offset conversion");

	chk_frac_clear: assert property (
		s_acc_write |=> st_reg.acc[ACC_FRAC_W-1:0] == '0 && st_reg.offset_conv)
		else $error("charge write left fraction or skipped calibration");

	chk_resume_second: assert property (
		s_forced_cal_done ##0 !wr_fire |=> !st_reg.offset_conv && $stable(st_reg.acc))
		else $error("forced calibration accumulated or did not resume");

	chk_acc_clamp_low: assert property (
		conv_end && !wr_fire && !st_reg.forced_conv && acc_sum < 0 |=> st_reg.acc == '0)
		else $error("charge did not clamp at zero");

	chk_blank_charge: assert property (
		conv_end && !st_reg.offset_conv && !wr_fire && cur_new > 0 && cur_new < CHG_BLANK_LSB
		&& st_reg.acc_bias == 8'h00 |=> $stable(st_reg.acc))
		else $error("small charge was accumulated");

	chk_cur_saturate: assert property (
		conv_end && !st_reg.offset_conv && cur_sum > SAT_POS |=> st_reg.cur == SAT_POS)
		else $error("current not saturated");

	chk_blank_discharge: assert property (
		conv_end && !st_reg.offset_conv && !wr_fire && st_reg.blank_en && cur_new < 0
		&& cur_new > -DIS_BLANK_LSB && st_reg.acc_bias == 8'h00 |=> $stable(st_reg.acc))
		else $error("small discharge was accumulated");

	// Sign bit test keeps negative sums out of the unsigned compare
	chk_acc_clamp_high: assert property (
		conv_end && !wr_fire && !st_reg.forced_conv && !acc_sum[ACC_W+1] && acc_sum > ACC_MAX
		|=> st_reg.acc == {ACC_W{1'b1}})
		else $error("charge did not clamp at full scale");

	chk_cur_only_end: assert property (
		!conv_end |=> $stable(st_reg.cur))
		else $error("current changed between conversion ends");

	chk_meas_only_tick: assert property (
		!meas_tick |=> $stable(st_reg.volt) && $stable(st_reg.temp))
		else $error("voltage or temperature changed off the tick");

	chk_sleep_blocked: assert property (
		!st_reg.sleep_en && !st_reg.sleep |=> !st_reg.sleep)
		else $error("sleep entered with sleep enable clear");

endmodule

// ---- tb/bcc_line_host.sv ----
// Host-side model of the two-wire bus line levels seen by the counter
module bcc_line_host (
	input  wire logic hold_low,
	output logic      bus_data_in,
	output logic      bus_clock_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released lines sit at the pull-up level, so an idle bus reads high
	// Holding both lines low is the only way the host lets the device sleep
	always_comb begin
		bus_data_in  = !hold_low;
		bus_clock_in = !hold_low;
	end
endmodule

// ---- tb/tb_bcc_counter.sv ----
// Self-checking testbench for the battery coulomb counter
module tb_bcc_counter
	import bcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned MC = 20;
	localparam int unsigned CC = 30;
	localparam int unsigned SC = 16;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, bus_data, bus_clock, hold_low;
	logic        sleep_mode, offset_select;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	bcc_adc_t    adc;
	int          n_fail;
	int          n_compared;

	bcc_counter #(.MEAS_CYCLES(MC), .CONV_CYCLES(CC), .SLEEP_CYCLES(SC)) bcc_counter_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus_data_in(bus_data),
		.bus_clock_in(bus_clock), .adc(adc), .sleep_mode(sleep_mode),
		.offset_select(offset_select)
	);
	bcc_line_host bcc_line_host_i (
		.hold_low(hold_low), .bus_data_in(bus_data), .bus_clock_in(bus_clock)
	);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic tally_and_finish();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic timed_out();
		n_fail++;
		tally_and_finish();
	endtask

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Ready flags are sampled mid-cycle so the edge that moves the item is never raced
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] resp);
		logic aw_t, w_t, b_t;
		b_t = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int i = 0; i < 100 && !b_t; i++) begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t  = wvalid && wready;
			b_t  = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) bready <= 1'b0;
		end
		if (!b_t) timed_out();
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar_t, r_t;
		r_t = 1'b0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int i = 0; i < 100 && !r_t; i++) begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t  = rvalid;
			d    = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 1'b0;
			if (r_t) rready <= 1'b0;
		end
		if (!r_t) timed_out();
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check(what, d, exp);
	endtask

	task automatic wait_for(input bit slp, input logic lvl, input int lim);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < lim && !hit; i++) begin
			@(negedge aclk);
			hit = ((slp ? sleep_mode : offset_select) === lvl);
		end
		@(posedge aclk);
		if (!hit) timed_out();
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		rdchk("config", ADDR_CONFIG, 32'h00000000);
		rdchk("current bias", ADDR_CUR_BIAS, 32'h00000000);
		rdchk("accumulation bias", ADDR_ACC_BIAS, 32'h00000000);
		rd(8'h40, d, r);
		check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
	endtask

	task automatic t_meas();
		adc.volt_raw <= 17'h00123;
		adc.temp_raw <= 16'hff38;
		// The input can change mid-period, so two full periods pass before the read
		wait_cycles(2 * MC + 2);
		rdchk("voltage", ADDR_VOLT, 32'h00000123);
		rdchk("temperature", ADDR_TEMP, 32'h0000ff38);
		adc.volt_raw <= 17'h0ffff;
		wait_cycles(2 * MC + 2);
		rdchk("voltage saturated", ADDR_VOLT, 32'h00007fff);
	endtask

	task automatic t_current();
		logic [1:0] r;
		wr(ADDR_CUR_BIAS, 32'h000000f0, 4'h1, r);
		adc.cur_raw <= 18'h00064;
		wait_cycles(2 * CC + 2);
		rdchk("biased current", ADDR_CURRENT, 32'h00000054);
		adc.cur_raw <= 18'h1ffff;
		wait_cycles(2 * CC + 2);
		rdchk("current saturated", ADDR_CURRENT, 32'h00007fff);
		wr(ADDR_CUR_BIAS, 32'h00000000, 4'h1, r);
	endtask

	// Raw input is zero across the forced offset conversion so the correction stays zero
	task automatic acc_run(input logic [15:0] start, input logic [17:0] raw, input logic [15:0] exp,
			input string what);
		logic [31:0] d;
		logic [1:0]  r;
		adc.cur_raw <= 18'h0;
		wr(ADDR_ACC, {16'h0, start}, 4'h3, r);
		wait_for(1'b0, 1'b1, 2 * CC);
		wait_for(1'b0, 1'b0, 2 * CC);
		adc.cur_raw <= raw;
		wait_cycles(CC / 2);
		rdchk("charge held", ADDR_ACC, {16'h0, start});
		wait_cycles(CC);
		rd(ADDR_ACC, d, r);
		check(what, d, {16'h0, exp});
	endtask

	// Calibration input is zero, then a steady 64 LSB charge runs to the scheduled calibration
	task automatic t_offset();
		logic [1:0] r;
		int         n;
		adc.cur_raw <= 18'h0;
		wr(ADDR_ACC, 32'h00000100, 4'h3, r);
		wait_for(1'b0, 1'b1, 2 * CC);
		wait_for(1'b0, 1'b0, 2 * CC);
		adc.cur_raw <= 18'h00040;
		for (n = 0; n < 1100 * CC && offset_select !== 1'b1; n++) begin
			@(negedge aclk);
		end
		check("offset period", n, 1023 * CC);
		if (offset_select !== 1'b1) timed_out();
		wait_for(1'b0, 1'b0, 2 * CC);
		rdchk("current at offset", ADDR_CURRENT, 32'h00000040);
		rdchk("charge at offset", ADDR_ACC, 32'h00000110);
		wait_cycles(CC);
		rdchk("corrected current", ADDR_CURRENT, 32'h00000000);
	endtask

	task automatic t_acc();
		logic [1:0] r;
		acc_run(16'h0100, 18'h02000, 16'h0102, "charge sum");
		wr(ADDR_CONFIG, 32'h00000002, 4'h1, r);
		acc_run(16'h0100, 18'h3fff8, 16'h0100, "discharge blanked");
		wr(ADDR_CONFIG, 32'h00000000, 4'h1, r);
		acc_run(16'h0100, 18'h3fff8, 16'h00ff, "discharge counted");
		acc_run(16'h0100, 18'h00040, 16'h0100, "fraction cleared");
		wr(ADDR_ACC_BIAS, 32'h000000ff, 4'h1, r);
		acc_run(16'h0100, 18'h0003f, 16'h00ff, "charge blanked");
		wr(ADDR_ACC_BIAS, 32'h00000000, 4'h1, r);
		acc_run(16'hffff, 18'h02000, 16'hffff, "clamp high");
		acc_run(16'h0001, 18'h3e000, 16'h0000, "clamp low");
	endtask

	task automatic t_sleep();
		logic [1:0] r;
		hold_low <= 1'b1;
		wait_cycles(SC + 8);
		@(negedge aclk);
		check("sleep disabled", {31'h0, sleep_mode}, 32'h0);
		@(posedge aclk);
		hold_low <= 1'b0;
		wr(ADDR_CONFIG, 32'h00000001, 4'h1, r);
		check("config resp", {30'h0, r}, {30'h0, RESP_OKAY});
		hold_low <= 1'b1;
		wait_cycles(SC - 4);
		@(negedge aclk);
		check("early sleep", {31'h0, sleep_mode}, 32'h0);
		wait_for(1'b1, 1'b1, 16);
		rdchk("config asleep", ADDR_CONFIG, 32'h00000101);
		adc.volt_raw <= 17'h00222;
		wait_cycles(2 * MC + 2);
		rdchk("voltage frozen", ADDR_VOLT, 32'h00007fff);
		hold_low <= 1'b0;
		wait_for(1'b1, 1'b0, 6);
		rdchk("config awake", ADDR_CONFIG, 32'h00000001);
		wait_cycles(2 * MC + 2);
		rdchk("voltage resumed", ADDR_VOLT, 32'h00000222);
		wr(ADDR_CONFIG, 32'h00000000, 4'h1, r);
	endtask

	initial begin
		n_fail = 0;
		n_compared = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, hold_low} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		adc = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_meas();
		t_current();
		t_acc();
		t_offset();
		t_sleep();
		tally_and_finish();
	end
endmodule
